/* core/mcju_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - A true condition on a far jump loads the chosen jump register.
// - The far form is 00111 in bits 15..11 and zero in bits 3..0.
// - A relative target is the own address plus the signed 5-bit offset.
// - The relative form is zero in bits 15..11, then condition and offset.
// - Codes 0..15 test flag n low and codes 16..31 test flag n high.
// - Codes 32..35 test the terminal counts of counters 1 to 4.
// - Code 36 is true for start low and code 37 for start high.
// - Codes 38..46 test shortcut drain low, source low, then drain high.
// - Code 47 is true once the last requested ALU operation has finished.
// - Code 48 is true for boost voltage high and code 49 for it low.
// - Codes 50..55 test six current feedbacks high and 56..61 low.
// - Code 62 tests own current feedback high and code 63 tests it low.
// - Flag 12 codes test current feedback 4 when that channel is on.
// - The channel configuration picks measurement 5 or 6 for shared tests.
// - An identity far jump is taken only if the core matches its select.
// - Far jumps reach any address held in the named jump register.
module mcju_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [9:0] jump_register_group [2],
  input wire mcju_pkg::mcju_src_t sources,
  input wire logic current_four_enable,
  input wire logic current_channel_config,
  input wire logic core_id,
  output logic [9:0] micro_program_counter,
  output logic jump_taken,
  output logic is_jump
);
  logic [9:0] pc_r;
  logic [9:0] pc_nxt;
  logic taken_r;
  logic is_jump_r;
  logic [5:0] cond;
  logic jump_register_select;
  logic core_identity_select;
  logic dec_far;
  logic dec_rel;
  logic dec_id;
  logic cond_true;
  logic [9:0] rel_tgt;
  logic [9:0] far_tgt;
  logic [9:0] seq_pc;
  logic flag_bit;
  logic [5:0] cur_vec;
  logic shared_current_low_threshold;
  logic shared_high;
  logic shared_neg;
  logic do_jump;

  // Field extraction
  assign cond = instr[mcju_pkg::COND_HI:mcju_pkg::COND_LO];
  assign jump_register_select = dec_id ? instr[mcju_pkg::ID_JRS_BIT] :
    instr[mcju_pkg::JRS_BIT];
  assign core_identity_select = instr[mcju_pkg::ID_SEL_BIT];

  // Decode of the three jump forms
  assign dec_far = (instr[mcju_pkg::OPC_HI:mcju_pkg::OPC_LO] ==
    mcju_pkg::OPC_FAR) && (instr[mcju_pkg::LOW4_HI:0] ==
    mcju_pkg::LOW_FAR);
  assign dec_rel = (instr[mcju_pkg::OPC_HI:mcju_pkg::OPC_LO] ==
    mcju_pkg::OPC_REL);
  assign dec_id = (instr[15:5] == mcju_pkg::ID_FAR_TOP) &&
    (instr[2:0] == mcju_pkg::ID_FAR_LOW);

  // Flag 12 gives way to current 4 when that channel is on
  assign flag_bit = (cond[3:0] == mcju_pkg::FLAG_CURRENT_FOUR_TEST &&
    current_four_enable) ? sources.current_four_test :
    sources.flags[cond[3:0]];

  // Only one of measurements 5/6 feeds the shared tests
  assign shared_current_low_threshold = current_channel_config ?
    sources.current56_low[1] : sources.current56_low[0];
  assign shared_high = current_channel_config ?
    sources.current56_high[1] : sources.current56_high[0];
  assign shared_neg = current_channel_config ?
    sources.current56_neg[1] : sources.current56_neg[0];
  assign cur_vec = {shared_neg, shared_high, shared_current_low_threshold,
    sources.current_low3};

  // Condition multiplexer, priority by code range
  always_comb begin
    cond_true = 1'b0;
    if (cond < 6'h10) begin
      cond_true = ~flag_bit;
    end else if (cond < mcju_pkg::C_TC) begin
      cond_true = flag_bit;
    end else if (cond < mcju_pkg::C_START_LO) begin
      cond_true = sources.terminal_count[cond[1:0]];
    end else if (cond == mcju_pkg::C_START_LO) begin
      cond_true = ~sources.start_level;
    end else if (cond == mcju_pkg::C_START_HI) begin
      cond_true = sources.start_level;
    end else if (cond < mcju_pkg::C_SCS_LO) begin
      cond_true = ~sources.shortcut_drain[
        2'(cond - mcju_pkg::C_SCV_LO)];
    end else if (cond < mcju_pkg::C_SCV_HI) begin
      cond_true = ~sources.shortcut_source[
        2'(cond - mcju_pkg::C_SCS_LO)];
    end else if (cond < mcju_pkg::C_ALU) begin
      cond_true = sources.shortcut_drain[2'(cond - mcju_pkg::C_SCV_HI)];
    end else if (cond == mcju_pkg::C_ALU) begin
      cond_true = sources.alu_done;
    end else if (cond == mcju_pkg::C_VB_HI) begin
      cond_true = sources.boost_level_test;
    end else if (cond == mcju_pkg::C_VB_LO) begin
      cond_true = ~sources.boost_level_test;
    end else if (cond < mcju_pkg::C_CUR_LO) begin
      cond_true = cur_vec[3'(cond - mcju_pkg::C_CUR_HI)];
    end else if (cond < mcju_pkg::C_OWN_HI) begin
      cond_true = ~cur_vec[3'(cond - mcju_pkg::C_CUR_LO)];
    end else if (cond == mcju_pkg::C_OWN_HI) begin
      cond_true = sources.own_current;
    end else begin
      cond_true = ~sources.own_current;
    end
  end

  // Targets; offset is sign-extended to the counter width
  assign rel_tgt = pc_r + {{5{instr[4]}}, instr[4:0]};
  assign far_tgt = jump_register_group[jump_register_select];
  assign seq_pc = pc_r + mcju_pkg::PC_ONE;
  assign do_jump = instr_valid && (((dec_far || dec_rel) && cond_true) ||
    (dec_id && core_id == core_identity_select));

  // Next counter value; false condition falls through
  always_comb begin
    pc_nxt = pc_r;
    if (instr_valid) begin
      pc_nxt = seq_pc;
      if (do_jump && dec_rel) begin
        pc_nxt = rel_tgt;
      end else if (do_jump) begin
        pc_nxt = far_tgt;
      end
    end
  end

  // Counter register; one instruction per valid cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      pc_r <= mcju_pkg::PC_RST;
      taken_r <= 1'b0;
      is_jump_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      taken_r <= do_jump;
      is_jump_r <= instr_valid && (dec_far || dec_rel || dec_id);
    end
  end

  assign micro_program_counter = pc_r;
  assign jump_taken = taken_r;
  assign is_jump = is_jump_r;

  a_far_load: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && dec_far && cond_true) |=>
    pc_r == $past(far_tgt))
    else $error("far jump target not loaded");
  a_rel_target: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && dec_rel && cond_true) |=>
    pc_r == 10'($past(pc_r) + {{5{$past(instr[4])}}, $past(instr[4:0])}))
    else $error("relative target wrong");
  a_fall_through: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && (dec_far || dec_rel) && !cond_true) |=>
    pc_r == 10'($past(pc_r) + 10'h001))
    else $error("false condition did not advance");
  a_id_match: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && dec_id && core_id != core_identity_select) |=>
    !jump_taken)
    else $error("identity jump taken on mismatch");
  a_flag_low: assert property (@(posedge clock) disable iff (reset)
    (cond < 6'h10 && !(cond[3:0] == 4'hC && current_four_enable)) |->
    cond_true == !sources.flags[cond[3:0]])
    else $error("flag low test wrong");
  a_current_four_test_swap: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h1C && current_four_enable) |->
    cond_true == sources.current_four_test)
    else $error("current four not substituted");
  a_start_test: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h25) |-> cond_true == sources.start_level)
    else $error("start test wrong");
  a_alu_poll: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h2F) |-> cond_true == sources.alu_done)
    else $error("alu done test wrong");
  a_own_low: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h3F) |-> cond_true == !sources.own_current)
    else $error("own current low test wrong");
  a_shared_sel: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h35) |->
    cond_true == sources.current56_low[current_channel_config])
    else $error("shared current channel wrong");

  // Far form with any low bit set, except the identity form, must not count as a jump
  a_far_nibble: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && instr[15:11] == 5'h07 && instr[3:0] != 4'h0 &&
    !(instr[15:5] == 11'h1CC && instr[2:0] == 3'h5)) |=> !is_jump)
    else $error("far form accepted with low bits set");

  // Far form with a clear low nibble is always reported as a jump
  a_far_decode: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && instr[15:11] == 5'h07 && instr[3:0] == 4'h0) |=>
    is_jump)
    else $error("far form not recognised");

  // Any word with a clear top field is a relative jump
  a_rel_decode: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && instr[15:11] == 5'h00) |=> is_jump)
    else $error("relative form not recognised");

  // Far target follows the select bit, not one fixed register
  a_far_reach: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && instr[15:11] == 5'h07 && instr[3:0] == 4'h0 &&
    cond_true) |=> pc_r == ($past(instr[4]) ?
    $past(jump_register_group[1]) : $past(jump_register_group[0])))
    else $error("far target from wrong register");

  // Identity form keeps its register select one bit below the far form
  a_id_taken: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && instr[15:5] == 11'h1CC && instr[2:0] == 3'h5 &&
    core_id == instr[4]) |=> jump_taken && pc_r == ($past(instr[3]) ?
    $past(jump_register_group[1]) : $past(jump_register_group[0])))
    else $error("identity jump not taken on match");

  // Mismatched identity falls through like any false condition
  a_id_advance: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && instr[15:5] == 11'h1CC && instr[2:0] == 3'h5 &&
    core_id != instr[4]) |=> pc_r == 10'($past(pc_r) + 10'h001))
    else $error("identity mismatch did not advance");

  // A false condition never reports a taken jump
  a_false_idle: assert property (@(posedge clock) disable iff (reset)
    (instr_valid && (dec_far || dec_rel) && !cond_true) |=> !jump_taken)
    else $error("false condition reported as taken");

  // Flag high codes; flag 12 with current 4 on is left to the swap checks
  a_flag_high: assert property (@(posedge clock) disable iff (reset)
    (cond[5:4] == 2'h1 && !(cond[3:0] == 4'hC && current_four_enable)) |->
    cond_true == sources.flags[cond[3:0]])
    else $error("flag high test wrong");

  // Low flag-12 code moves over to current 4 as well
  a_current_four_test_low: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h0C && current_four_enable) |->
    cond_true == !sources.current_four_test)
    else $error("current four low not substituted");

  // Last terminal count code picks counter 4
  a_term_count: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h23) |-> cond_true == sources.terminal_count[3])
    else $error("terminal count test wrong");

  // Start low polarity
  a_start_low: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h24) |-> cond_true == !sources.start_level)
    else $error("start low test wrong");

  // First shortcut drain low
  a_drain_low: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h26) |-> cond_true == !sources.shortcut_drain[0])
    else $error("shortcut drain low test wrong");

  // Third shortcut source low
  a_source_low: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h2B) |-> cond_true == !sources.shortcut_source[2])
    else $error("shortcut source low test wrong");

  // Third shortcut drain high
  a_drain_high: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h2E) |-> cond_true == sources.shortcut_drain[2])
    else $error("shortcut drain high test wrong");

  // Boost indication high
  a_boost_high: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h30) |-> cond_true == sources.boost_level_test)
    else $error("boost high test wrong");

  // Boost indication low
  a_boost_low: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h31) |-> cond_true == !sources.boost_level_test)
    else $error("boost low test wrong");

  // Current feedback 1 high
  a_cur_high: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h32) |-> cond_true == sources.current_low3[0])
    else $error("current high test wrong");

  // Current feedback 3 low
  a_cur_low: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h3A) |-> cond_true == !sources.current_low3[2])
    else $error("current low test wrong");

  // Shared negative threshold follows the channel choice
  a_shared_neg: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h37) |->
    cond_true == sources.current56_neg[current_channel_config])
    else $error("shared negative channel wrong");

  // Shared high threshold low test follows the channel choice
  a_shared_high: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h3C) |->
    cond_true == !sources.current56_high[current_channel_config])
    else $error("shared high channel wrong");

  // Own current feedback high
  a_own_high: assert property (@(posedge clock) disable iff (reset)
    (cond == 6'h3E) |-> cond_true == sources.own_current)
    else $error("own current high test wrong");
endmodule : mcju_top

/* inc/mcju_pkg.sv */
package mcju_pkg;
  // Instruction layout
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 11;
  localparam int COND_HI = 10;
  localparam int COND_LO = 5;
  localparam int JRS_BIT = 4;
  localparam int DEST_HI = 4;
  localparam int DEST_LO = 0;
  localparam int LOW4_HI = 3;
  localparam logic [4:0] OPC_FAR = 5'h07;
  localparam logic [4:0] OPC_REL = 5'h00;
  localparam logic [3:0] LOW_FAR = 4'h0;
  // Core identity jump: 00111 001100 sel jr 101
  localparam logic [10:0] ID_FAR_TOP = 11'h1CC;
  localparam logic [2:0] ID_FAR_LOW = 3'h5;
  localparam int ID_SEL_BIT = 4;
  localparam int ID_JRS_BIT = 3;
  // Address width of code memory
  localparam int PC_W = 10;
  localparam logic [9:0] PC_RST = 10'h000;
  localparam logic [9:0] PC_ONE = 10'h001;
  // Condition code groups
  localparam logic [5:0] C_TC = 6'h20;
  localparam logic [5:0] C_START_LO = 6'h24;
  localparam logic [5:0] C_START_HI = 6'h25;
  localparam logic [5:0] C_SCV_LO = 6'h26;
  localparam logic [5:0] C_SCS_LO = 6'h29;
  localparam logic [5:0] C_SCV_HI = 6'h2C;
  localparam logic [5:0] C_ALU = 6'h2F;
  localparam logic [5:0] C_VB_HI = 6'h30;
  localparam logic [5:0] C_VB_LO = 6'h31;
  localparam logic [5:0] C_CUR_HI = 6'h32;
  localparam logic [5:0] C_CUR_LO = 6'h38;
  localparam logic [5:0] C_OWN_HI = 6'h3E;
  localparam logic [5:0] C_OWN_LO = 6'h3F;
  localparam logic [3:0] FLAG_CURRENT_FOUR_TEST = 4'hC;

  // Condition sources
  typedef struct packed {
    logic [15:0] flags;
    logic [3:0] terminal_count;
    logic start_level;
    logic [2:0] shortcut_drain;
    logic [2:0] shortcut_source;
    logic alu_done;
    logic boost_level_test;
    logic [2:0] current_low3;
    logic current_four_test;
    logic [1:0] current56_low;
    logic [1:0] current56_high;
    logic [1:0] current56_neg;
    logic own_current;
  } mcju_src_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_HOLD = 3'b100
  } mcju_state_t;
endpackage : mcju_pkg

/* test/mcju_src_model.sv */
`timescale 1ns/1ps
// Drives one condition source to a level and all others to the inverse,
// so a decoder that picks the wrong source reads the opposite answer
module mcju_src_model (
  input wire logic [5:0] sel_bit,
  input wire logic level,
  output mcju_pkg::mcju_src_t sources
);
  logic [39:0] flat;
  // Inverse background rather than zero: a stale pick cannot pass by luck
  always_comb begin
    flat = {40{~level}};
    flat[sel_bit] = level;
  end
  assign sources = mcju_pkg::mcju_src_t'(flat);
endmodule : mcju_src_model

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [9:0] jregs [2] = '{10'h2A5, 10'h15A};
  mcju_pkg::mcju_src_t sources;
  logic c4_en = 1'b0;
  logic chan_cfg = 1'b0;
  logic core_id = 1'b0;
  logic [5:0] sel_bit = 6'h00;
  logic level = 1'b0;
  logic [9:0] micro_program_counter;
  logic jump_taken;
  logic is_jump;
  logic [9:0] pc_exp;
  logic [4:0] off;
  logic jr;
  int miscompares = 0;
  int checks_done = 0;

  always #50 clock = ~clock;

  mcju_top dut_u (
    .clock(clock),
    .reset(reset),
    .instr_valid(instr_valid),
    .instr(instr),
    .jump_register_group(jregs),
    .sources(sources),
    .current_four_enable(c4_en),
    .current_channel_config(chan_cfg),
    .core_id(core_id),
    .micro_program_counter(micro_program_counter),
    .jump_taken(jump_taken),
    .is_jump(is_jump)
  );

  mcju_src_model src_u (
    .sel_bit(sel_bit),
    .level(level),
    .sources(sources)
  );

  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One instruction per cycle, outputs checked at the following low phase
  task automatic run(input logic [15:0] ins, input logic tk,
                     input logic ij, input logic [9:0] tgt);
    logic [9:0] nxt;
    instr = ins;
    instr_valid = 1'b1;
    @(negedge clock);
    nxt = tk ? tgt : pc_exp + mcju_pkg::PC_ONE;
    chk({6'h00, micro_program_counter}, {6'h00, nxt});
    chk({15'h0000, jump_taken}, {15'h0000, tk});
    chk({15'h0000, is_jump}, {15'h0000, ij});
    pc_exp = nxt;
  endtask : run

  // Source bit and true level for a test code, as {level, bit index}
  function automatic logic [6:0] cond_src(input logic [5:0] c,
                                          input logic cf, input logic c4);
    int k;
    if (c == 6'h0C && c4) return {1'b0, 6'd7};
    if (c == 6'h1C && c4) return {1'b1, 6'd7};
    if (c < 16) return {1'b0, 6'(24 + c)};
    if (c < 32) return {1'b1, 6'(8 + c)};
    if (c < 36) return {1'b1, 6'(c - 12)};
    if (c < 38) return {c[0], 6'd19};
    if (c < 41) return {1'b0, 6'(c - 22)};
    if (c < 44) return {1'b0, 6'(c - 28)};
    if (c < 47) return {1'b1, 6'(c - 28)};
    if (c == 47) return {1'b1, 6'd12};
    if (c < 50) return {~c[0], 6'd11};
    if (c > 61) return {~c[0], 6'd0};
    k = (int'(c) - 50) % 6;
    return {c < 56, 6'(k < 3 ? 8 + k : 11 - 2 * k + int'(cf))};
  endfunction : cond_src

  // Every code, both polarities, both forms, all channel settings
  initial begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    pc_exp = mcju_pkg::PC_RST;
    for (int m = 0; m < 4; m++) begin
      {c4_en, chan_cfg} = 2'(m);
      for (int c = 0; c < 64; c++) begin
        for (int p = 0; p < 2; p++) begin
          {level, sel_bit} = cond_src(6'(c), chan_cfg, c4_en);
          level = level ^ p[0];
          off = 5'(c + m);
          jr = 1'(c ^ p);
          run({5'h00, 6'(c), off}, !p[0], 1'b1,
              pc_exp + {{5{off[4]}}, off});
          run({5'h07, 6'(c), jr, 4'h0}, !p[0], 1'b1, jregs[jr]);
        end
      end
    end
    // Nonzero low nibble is not the far conditional form
    {level, sel_bit} = cond_src(6'h00, chan_cfg, c4_en);
    run(16'h3808, 1'b0, 1'b0, 10'h000);
    for (int n = 0; n < 8; n++) begin
      core_id = n[2];
      run(16'h3985 | (16'(n[1:0]) << 3), n[2] == n[1], 1'b1,
          jregs[n[0]]);
    end
    // Counter holds while no instruction executes
    instr_valid = 1'b0;
    repeat (3) @(negedge clock);
    chk({6'h00, micro_program_counter}, {6'h00, pc_exp});
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    chk({6'h00, micro_program_counter}, {6'h00, mcju_pkg::PC_RST});
    chk({15'h0000, jump_taken}, 16'h0000);
    conclude();
  end

  // Hang guard well beyond the some 1045 cycles needed
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule : tb_top
